/* File: rtl/msb_pkg.sv */
// Purpose: Shared constants for the stall and battery supervisor
// Assumes: Voltages in tenths of a volt, factors in tenths, levels in percent
// Notes: Register addresses are word indices on the plain register port
package msb_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int AW = 4;
  localparam int VW = 9;
  // Register addresses
  localparam logic [AW-1:0] A_STALL = 4'h0;
  localparam logic [AW-1:0] A_VOLT = 4'h1;
  localparam logic [AW-1:0] A_RSTV = 4'h2;
  localparam logic [AW-1:0] A_FACT = 4'h3;
  localparam logic [AW-1:0] A_LOW = 4'h4;
  localparam logic [AW-1:0] A_LOCK = 4'h5;
  localparam logic [AW-1:0] A_COMP = 4'h6;
  localparam logic [AW-1:0] A_STAT = 4'h7;
  // Field positions, multi-bit fields spaced ten bits apart
  localparam int F_SSPD = 0;
  localparam int F_SDUTY = 10;
  localparam int F_TMO = 20;
  localparam int F_STARTV = 0;
  localparam int F_FULLV = 10;
  localparam int F_RSTV = 0;
  localparam int F_DCHG = 0;
  localparam int F_CHG = 10;
  localparam int F_LLVL = 0;
  localparam int F_LSPD = 10;
  localparam int F_LEN = 0;
  localparam int F_LEXT = 1;
  localparam int F_LPOL = 2;
  localparam int F_LTH = 10;
  localparam int F_COMP = 0;
  localparam int F_NEAR = 10;
  localparam int F_ST_STALL = 0;
  localparam int F_ST_CHG = 1;
  localparam int F_ST_LOCK = 2;
  localparam int F_ST_LIM = 3;
  localparam int F_ST_EST = 10;
  // Reset values
  localparam logic [7:0] RST_SSPD = 8'h05;
  localparam logic [6:0] RST_SDUTY = 7'h32;
  localparam logic [5:0] RST_TMO = 6'h10;
  localparam logic [VW-1:0] RST_STARTV = 9'h0e6;
  localparam logic [VW-1:0] RST_FULLV = 9'h0fa;
  localparam logic [VW-1:0] RST_RSTV = 9'h0dc;
  localparam logic [6:0] RST_FACT = 7'h0a;
  localparam logic [6:0] RST_LLVL = 7'h00;
  localparam logic [6:0] RST_LSPD = 7'h64;
  localparam logic [5:0] RST_LTH = 6'h00;
  localparam logic [6:0] RST_COMP = 7'h00;
  localparam logic [7:0] RST_NEAR = 8'h02;
  localparam logic [6:0] RST_EST = 7'h32;
  localparam logic [6:0] PCT_FULL = 7'h64;
  // Programming ranges
  localparam logic [VW-1:0] V_ZERO = 9'h000;
  localparam logic [VW-1:0] V_PCT = 9'h064;
  localparam logic [VW-1:0] TMO_MIN = 9'h010;
  localparam logic [VW-1:0] TMO_MAX = 9'h020;
  localparam logic [VW-1:0] LSPD_MIN = 9'h00a;
  localparam logic [VW-1:0] LTH_MAX = 9'h032;
  localparam logic [VW-1:0] FAC_MIN = 9'h001;
  localparam logic [VW-1:0] COMP_MAX = 9'h07d;
  localparam logic [VW-1:0] SV_MIN = 9'h0d2;
  localparam logic [VW-1:0] SV_MAX = 9'h122;
  localparam logic [VW-1:0] FV_MIN = 9'h0f0;
  localparam logic [VW-1:0] FV_MAX = 9'h140;
  localparam logic [VW-1:0] RV_MIN = 9'h0c8;
  localparam logic [VW-1:0] RV_MAX = 9'h118;
endpackage

/* File: rtl/msb_est_if.sv */
// Purpose: Link between supervisor and charge estimator
// Assumes: One clock domain
// Notes: Supervisor drives settings and tick, estimator answers
`timescale 1ns/1ps
`default_nettype none
interface msb_est_if;
  logic tick;
  logic drive;
  logic [8:0] volt;
  logic [8:0] start_v;
  logic [8:0] full_v;
  logic [8:0] reset_v;
  logic [6:0] dchg_f;
  logic [6:0] chg_f;
  logic [6:0] estimate;
  logic charging;
  modport est (input tick, drive, volt, start_v, full_v, reset_v, dchg_f, chg_f,
    output estimate, charging);
  modport sup (output tick, drive, volt, start_v, full_v, reset_v, dchg_f, chg_f,
    input estimate, charging);
endinterface
`default_nettype wire

/* File: rtl/msb_charge_est.sv */
// Purpose: Battery charge estimate with charge and discharge tracking
// Assumes: One tick per second from the supervisor
// Notes: Estimate moves one percent per factor count of ticks
`timescale 1ns/1ps
`default_nettype none
module msb_charge_est (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Supervisor link
  msb_est_if.est b
);
  import msb_pkg::*;
  typedef enum logic [1:0] {EST_PWRUP, EST_RUN, EST_CHARGE} msb_est_st_t;
  typedef struct packed {
    msb_est_st_t st;
    logic [6:0] est;
    logic [6:0] cnt;
  } msb_est_t;
  msb_est_t s;
  msb_est_t n;

  always_comb
  begin
    n = s;
    case (s.st)
      EST_PWRUP:
      begin
        if (b.volt >= b.reset_v)
        begin
          n.est = PCT_FULL;
          n.st = EST_RUN;
        end
        else if (b.tick)
          n.st = EST_RUN;
      end
      EST_RUN:
      begin
        if (b.volt > b.start_v)
        begin
          n.st = EST_CHARGE;
          n.cnt = '0;
        end
        else if (b.tick && b.drive)
        begin
          n.cnt = 7'(s.cnt + 7'h01);
          if (n.cnt >= b.dchg_f)
          begin
            n.cnt = '0;
            if (s.est != '0)
              n.est = 7'(s.est - 7'h01);
          end
        end
      end
      EST_CHARGE:
      begin
        // Full check first, so a full level set below start still completes
        if (b.volt > b.full_v)
          n.est = PCT_FULL;
        else if (b.volt <= b.start_v)
          n.st = EST_RUN;
        else if (b.tick)
        begin
          n.cnt = 7'(s.cnt + 7'h01);
          if (n.cnt >= b.chg_f)
          begin
            n.cnt = '0;
            if (s.est < PCT_FULL)
              n.est = 7'(s.est + 7'h01);
          end
        end
      end
      default: n.st = EST_PWRUP;
    endcase
    if (srst_i)
    begin
      n.st = EST_PWRUP;
      n.est = RST_EST;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
    s <= n;

  assign b.estimate = s.est;
  assign b.charging = (s.st == EST_CHARGE);

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  pwrup_full_a: assert property (s.st == EST_PWRUP && b.volt >= b.reset_v
    |=> b.estimate == PCT_FULL && !b.charging) else $error("reset to full missed");
  chg_start_a: assert property (s.st == EST_RUN && b.volt > b.start_v
    |=> b.charging) else $error("charging not entered");
  chg_full_a: assert property (b.charging && b.volt > b.full_v
    |=> b.estimate == PCT_FULL) else $error("full charge not taken");
  rate_slow_a: assert property (b.tick && s.st == EST_RUN && 7'(s.cnt + 7'h01) < b.dchg_f
    |=> $stable(b.estimate)) else $error("estimate moved too fast");
endmodule
`default_nettype wire

/* File: rtl/msb_top.sv */
// Purpose: Motor stall fault, battery charge tracking and lift lockout
// Assumes: Measurements synchronous to clk_i; voltage in tenths of a volt
// Notes: Settings are clamped to their legal range when written
// Contract
// - Stall fault when speed and duty both below settings past the timeout
// - Stall duty threshold is a 0 to 100 percent setting for stall only
// - Stall timeout programmable 16 to 32 seconds, sets persistence time
// - Below low charge level, speed cap equals low charge speed, 10 to 100
// - Low charge level 0 to 100 percent; zero disables speed limiting
// - External select takes lockout from input, else from charge estimate
// - Lockout enabled takes shared output from horn; disabled drives horn
// - Internal lockout active when estimate below threshold, 0 to 50 percent
// - Polarity 0 pulls output low when active, 1 leaves it open
// - At power-up, estimate goes to full if voltage reaches reset voltage before the first tick, else it stays at 50
// - Charging begins once voltage rises above start-charge voltage
// - While charging, voltage above full-charge voltage completes charge
// - Charge and discharge factors 0.1 to 10.0, larger means slower
// - Hill-hold compensation only at neutral throttle and near-zero speed
`timescale 1ns/1ps
`default_nettype none
module msb_top #(
  parameter int TICK_CYCLES = msb_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [msb_pkg::AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Drive and battery measurements
  input wire logic [7:0] speed_est_i,
  input wire logic [6:0] duty_i,
  input wire logic [msb_pkg::VW-1:0] batt_volt_i,
  input wire logic throttle_neutral_i,
  // Lockout and horn
  input wire logic lift_lockout_i,
  input wire logic horn_req_i,
  output logic shared_out_o,
  output logic shared_oe_o,
  output logic lockout_active_o,
  // Supervisory results
  output logic stall_fault_o,
  output logic [6:0] speed_cap_o,
  output logic [6:0] hill_comp_o,
  output logic [6:0] battery_charge_estimate_o,
  output logic charging_o
);
  import msb_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2)
  begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [7:0] stall_spd;
    logic [6:0] stall_duty;
    logic [5:0] tmo;
    logic [VW-1:0] start_v;
    logic [VW-1:0] full_v;
    logic [VW-1:0] reset_v;
    logic [6:0] dchg_f;
    logic [6:0] chg_f;
    logic [6:0] low_lvl;
    logic [6:0] low_spd;
    logic lk_en;
    logic lk_ext;
    logic lk_pol;
    logic [5:0] lk_th;
    logic [6:0] comp;
    logic [7:0] near;
    logic [TW-1:0] div;
    logic tick;
    logic [TW-1:0] sub;
    logic [5:0] secs;
    logic stall;
    logic lk_act;
    logic oe;
    logic limited;
    logic [6:0] cap;
    logic [6:0] hold;
    logic [31:0] rdata;
  } msb_state_t;

  msb_state_t s;
  msb_state_t n;
  logic stall_cond;
  logic [6:0] est;
  msb_est_if bus();

  function automatic logic [VW-1:0] fld(input logic [31:0] d, input int lsb);
    return d[lsb +: VW];
  endfunction

  // Out-of-range writes saturate instead of being refused
  function automatic logic [VW-1:0] clampv(input logic [VW-1:0] v,
    input logic [VW-1:0] lo, input logic [VW-1:0] hi);
    if (v < lo)
      return lo;
    if (v > hi)
      return hi;
    return v;
  endfunction

  assign est = bus.estimate;
  assign stall_cond = (speed_est_i < s.stall_spd) && (duty_i < s.stall_duty);

  always_comb
  begin
    n = s;
    n.tick = 1'b0;
    n.rdata = '0;
    if (s.div == TICK_LAST)
    begin
      n.div = '0;
      n.tick = 1'b1;
    end
    else
      n.div = TW'(s.div + 1'b1);

    // Stall timer has its own phase so the timeout is exact
    if (!stall_cond)
    begin
      n.sub = '0;
      n.secs = '0;
    end
    else if (s.secs < s.tmo)
    begin
      if (s.sub == TICK_LAST)
      begin
        n.sub = '0;
        n.secs = 6'(s.secs + 6'h01);
      end
      else
        n.sub = TW'(s.sub + 1'b1);
    end

    if (wr_i)
    begin
      case (addr_i)
        A_STALL:
        begin
          n.stall_spd = wdata_i[F_SSPD +: 8];
          n.stall_duty = 7'(clampv(fld(wdata_i, F_SDUTY), V_ZERO, V_PCT));
          n.tmo = 6'(clampv(fld(wdata_i, F_TMO), TMO_MIN, TMO_MAX));
        end
        A_VOLT:
        begin
          n.start_v = clampv(fld(wdata_i, F_STARTV), SV_MIN, SV_MAX);
          n.full_v = clampv(fld(wdata_i, F_FULLV), FV_MIN, FV_MAX);
        end
        A_RSTV: n.reset_v = clampv(fld(wdata_i, F_RSTV), RV_MIN, RV_MAX);
        A_FACT:
        begin
          n.dchg_f = 7'(clampv(fld(wdata_i, F_DCHG), FAC_MIN, V_PCT));
          n.chg_f = 7'(clampv(fld(wdata_i, F_CHG), FAC_MIN, V_PCT));
        end
        A_LOW:
        begin
          n.low_lvl = 7'(clampv(fld(wdata_i, F_LLVL), V_ZERO, V_PCT));
          n.low_spd = 7'(clampv(fld(wdata_i, F_LSPD), LSPD_MIN, V_PCT));
        end
        A_LOCK:
        begin
          n.lk_en = wdata_i[F_LEN];
          n.lk_ext = wdata_i[F_LEXT];
          n.lk_pol = wdata_i[F_LPOL];
          n.lk_th = 6'(clampv(fld(wdata_i, F_LTH), V_ZERO, LTH_MAX));
        end
        A_COMP:
        begin
          n.comp = 7'(clampv(fld(wdata_i, F_COMP), V_ZERO, COMP_MAX));
          n.near = wdata_i[F_NEAR +: 8];
        end
        A_STAT:
          if (wdata_i[F_ST_STALL])
            n.stall = 1'b0;
        default: n.stall = n.stall;
      endcase
    end
    // Set after clear, so a fault in the clearing cycle survives
    if (stall_cond && s.secs >= s.tmo)
      n.stall = 1'b1;

    if (s.lk_ext)
      n.lk_act = s.lk_en && lift_lockout_i;
    else
      n.lk_act = s.lk_en && (est < {1'b0, s.lk_th});
    if (s.lk_en)
      n.oe = n.lk_act ^ s.lk_pol;
    else
      n.oe = horn_req_i;

    n.limited = (s.low_lvl != '0) && (est < s.low_lvl);
    n.cap = n.limited ? s.low_spd : PCT_FULL;
    if (throttle_neutral_i && speed_est_i <= s.near)
      n.hold = s.comp;
    else
      n.hold = '0;

    if (rd_i)
    begin
      case (addr_i)
        A_STALL:
        begin
          n.rdata[F_SSPD +: 8] = s.stall_spd;
          n.rdata[F_SDUTY +: 7] = s.stall_duty;
          n.rdata[F_TMO +: 6] = s.tmo;
        end
        A_VOLT:
        begin
          n.rdata[F_STARTV +: VW] = s.start_v;
          n.rdata[F_FULLV +: VW] = s.full_v;
        end
        A_RSTV: n.rdata[F_RSTV +: VW] = s.reset_v;
        A_FACT:
        begin
          n.rdata[F_DCHG +: 7] = s.dchg_f;
          n.rdata[F_CHG +: 7] = s.chg_f;
        end
        A_LOW:
        begin
          n.rdata[F_LLVL +: 7] = s.low_lvl;
          n.rdata[F_LSPD +: 7] = s.low_spd;
        end
        A_LOCK:
        begin
          n.rdata[F_LEN] = s.lk_en;
          n.rdata[F_LEXT] = s.lk_ext;
          n.rdata[F_LPOL] = s.lk_pol;
          n.rdata[F_LTH +: 6] = s.lk_th;
        end
        A_COMP:
        begin
          n.rdata[F_COMP +: 7] = s.comp;
          n.rdata[F_NEAR +: 8] = s.near;
        end
        A_STAT:
        begin
          n.rdata[F_ST_STALL] = s.stall;
          n.rdata[F_ST_CHG] = bus.charging;
          n.rdata[F_ST_LOCK] = s.lk_act;
          n.rdata[F_ST_LIM] = s.limited;
          n.rdata[F_ST_EST +: 7] = est;
        end
        default: n.rdata = '0;
      endcase
    end

    if (srst_i)
    begin
      n = '0;
      n.stall_spd = RST_SSPD;
      n.stall_duty = RST_SDUTY;
      n.tmo = RST_TMO;
      n.start_v = RST_STARTV;
      n.full_v = RST_FULLV;
      n.reset_v = RST_RSTV;
      n.dchg_f = RST_FACT;
      n.chg_f = RST_FACT;
      n.low_lvl = RST_LLVL;
      n.low_spd = RST_LSPD;
      n.lk_th = RST_LTH;
      n.comp = RST_COMP;
      n.near = RST_NEAR;
      n.cap = PCT_FULL;
    end
  end

  always_ff @(posedge clk_i)
    s <= n;

  assign bus.tick = s.tick;
  assign bus.drive = (duty_i != '0);
  assign bus.volt = batt_volt_i;
  assign bus.start_v = s.start_v;
  assign bus.full_v = s.full_v;
  assign bus.reset_v = s.reset_v;
  assign bus.dchg_f = s.dchg_f;
  assign bus.chg_f = s.chg_f;

  msb_charge_est u_est (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .b (bus.est)
  );

  // Low-side driver: the pin is only ever pulled low or released
  assign shared_out_o = 1'b0;
  assign shared_oe_o = s.oe;
  assign lockout_active_o = s.lk_act;
  assign stall_fault_o = s.stall;
  assign speed_cap_o = s.cap;
  assign hill_comp_o = s.hold;
  assign battery_charge_estimate_o = est;
  assign charging_o = bus.charging;
  assign rdata_o = s.rdata;

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence stall_expire;
    stall_cond && s.secs >= s.tmo;
  endsequence
  sequence stall_broken;
    !stall_cond ##1 1'b1;
  endsequence

  stall_set_a: assert property (stall_expire |=> stall_fault_o)
    else $error("stall fault not raised");
  stall_cause_a: assert property ($rose(stall_fault_o) |-> $past(stall_cond)
    && $past(s.secs) >= $past(s.tmo)) else $error("stall fault without cause");
  stall_duty_a: assert property (duty_i >= s.stall_duty |=> s.secs == '0)
    else $error("duty above threshold still timed");
  tmo_range_a: assert property (s.tmo >= 6'h10 && s.tmo <= 6'h20)
    else $error("timeout out of range");
  timer_restart_a: assert property (stall_broken |-> s.sub == '0 && s.secs == '0)
    else $error("stall timer not restarted");
  low_cap_a: assert property (s.low_lvl != '0 && est < s.low_lvl
    |=> speed_cap_o == $past(s.low_spd)) else $error("low charge cap missing");
  no_limit_a: assert property (s.low_lvl == '0 |=> speed_cap_o == PCT_FULL)
    else $error("limit with level zero");
  ext_source_a: assert property (s.lk_en && s.lk_ext
    |=> lockout_active_o == $past(lift_lockout_i)) else $error("external lockout wrong");
  horn_pass_a: assert property (!s.lk_en |=> shared_oe_o == $past(horn_req_i)
    && !lockout_active_o) else $error("horn not driven");
  int_source_a: assert property (s.lk_en && !s.lk_ext && est < {1'b0, s.lk_th}
    |=> lockout_active_o) else $error("internal lockout missed");
  lock_pol_a: assert property (lockout_active_o |-> shared_oe_o != $past(s.lk_pol))
    else $error("lockout polarity wrong");
  hill_gate_a: assert property (!throttle_neutral_i |=> hill_comp_o == '0)
    else $error("hill hold outside neutral");
endmodule
`default_nettype wire

/* File: test/msb_vehicle_model.sv */
// Purpose: Battery and pump relay seen from the supervisor's pins
// Assumes: Relay coil to supply, pin pulled up when released
// Notes: Battery voltage settles one clock after a change
`timescale 1ns/1ps
`default_nettype none
module msb_vehicle_model (
  // Clock
  input wire logic clk_i,
  // Bench settings
  input wire logic [msb_pkg::VW-1:0] volt_set_i,
  // Shared pin from the supervisor
  input wire logic shared_out_i,
  input wire logic shared_oe_i,
  // Battery and relay
  output logic [msb_pkg::VW-1:0] batt_volt_o,
  output logic pin_level_o
);
  import msb_pkg::*;
  always_ff @(posedge clk_i)
  begin
    batt_volt_o <= volt_set_i;
  end
  // Released pin floats up to the coil supply
  assign pin_level_o = shared_oe_i ? shared_out_i : 1'b1;
endmodule
`default_nettype wire

/* File: test/test_motor_stall_and_battery_lockout.sv */
// Purpose: Self-checking bench for the stall and battery supervisor
// Assumes: Short tick of 8 cycles stands for one second
// Notes: Estimator ticks make some figures drift by one count
`timescale 1ns/1ps
`default_nettype none
module test_motor_stall_and_battery_lockout;
  import msb_pkg::*;
  localparam int TK = 8;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [AW-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] speed_est_i = 8'h32;
  logic [6:0] duty_i = 7'h00;
  logic throttle_neutral_i = 1'b0;
  logic lift_lockout_i = 1'b0;
  logic horn_req_i = 1'b0;
  logic [VW-1:0] volt_set = 9'h0d7;
  logic [VW-1:0] batt_volt;
  logic [31:0] rdata_o;
  logic shared_out_o, shared_oe_o, lockout_active_o, stall_fault_o, charging_o, pin;
  logic [6:0] speed_cap_o, hill_comp_o, est, e1;
  logic [31:0] q;
  logic [31:0] rv [0:8];
  logic [31:0] sw [0:5];
  logic [31:0] sx [0:5];
  logic [3:0] sa [0:5];
  int mismatches = 0;
  int n_tests = 0;
  int l;
  always #25 clk_i = ~clk_i;
  msb_vehicle_model msb_vehicle_model_inst (.clk_i(clk_i), .volt_set_i(volt_set),
    .shared_out_i(shared_out_o), .shared_oe_i(shared_oe_o), .batt_volt_o(batt_volt),
    .pin_level_o(pin));
  msb_top #(.TICK_CYCLES(TK)) msb_top_inst (.clk_i(clk_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .speed_est_i(speed_est_i), .duty_i(duty_i), .batt_volt_i(batt_volt),
    .throttle_neutral_i(throttle_neutral_i), .lift_lockout_i(lift_lockout_i),
    .horn_req_i(horn_req_i), .shared_out_o(shared_out_o), .shared_oe_o(shared_oe_o),
    .lockout_active_o(lockout_active_o), .stall_fault_o(stall_fault_o),
    .speed_cap_o(speed_cap_o), .hill_comp_o(hill_comp_o),
    .battery_charge_estimate_o(est), .charging_o(charging_o));
  // Register word with fields at bits 0, 10 and 20
  function automatic logic [31:0] f3(input logic [9:0] a, input logic [9:0] b,
    input logic [9:0] c);
    return {2'h0, c, b, a};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic do_reset(input logic [VW-1:0] v);
    volt_set <= v;
    srst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Stall condition held with random values under the settings
  task automatic hold(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      speed_est_i <= 8'($urandom_range(0, 9));
      duty_i <= 7'($urandom_range(1, 39));
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'hd0a9));
    rv = '{f3(10'(RST_SSPD), 10'(RST_SDUTY), 10'(RST_TMO)),
      f3(10'(RST_STARTV), 10'(RST_FULLV), 0), f3(10'(RST_RSTV), 0, 0),
      f3(10'(RST_FACT), 10'(RST_FACT), 0), f3(10'(RST_LLVL), 10'(RST_LSPD), 0),
      f3(0, 10'(RST_LTH), 0), f3(10'(RST_COMP), 10'(RST_NEAR), 0),
      f3(0, 10'(RST_EST), 0), 32'h0000_0000};
    sa = '{A_STALL, A_STALL, A_LOW, A_LOCK, A_FACT, A_COMP};
    sw = '{f3(10, 120, 5), f3(10, 40, 40), f3(60, 3, 0), f3(1, 60, 0), f3(0, 100, 0),
      f3(127, 9, 0)};
    sx = '{f3(10, 100, 16), f3(10, 40, 32), f3(60, 10, 0), f3(1, 50, 0), f3(1, 100, 0),
      f3(125, 9, 0)};
    do_reset(9'h0d7);
    for (int i = 0; i < 9; i++)
    begin
      rd(4'(i), q);
      chk("reset word", q, rv[i]);
    end
    chk("cap at reset", 32'(speed_cap_o), 32'h64);
    // Out-of-range settings land on the nearest bound
    for (int i = 0; i < 6; i++)
    begin
      wr(sa[i], sw[i]);
      rd(sa[i], q);
      chk("saturated", q, sx[i]);
    end
    wr(A_COMP, f3(125, 2, 0));
    for (int i = 0; i < 10; i++)
    begin
      throttle_neutral_i <= 1'($urandom());
      speed_est_i <= 8'($urandom_range(0, 4));
      repeat (3) @(posedge clk_i);
      chk("hill", 32'(hill_comp_o), (throttle_neutral_i && speed_est_i <= 2) ? 125 : 0);
    end
    speed_est_i <= 8'h32;
    l = $urandom_range(10, 100);
    foreach (sa[i])
    begin
      // Estimate sits at 50 with no drive
      wr(A_LOW, f3(10'(i * 20), 10'(l), 0));
      repeat (3) @(posedge clk_i);
      chk("cap", 32'(speed_cap_o), (i != 0 && i * 20 > 50) ? l : 100);
    end
    wr(A_LOCK, 32'h0);
    repeat (8)
    begin
      horn_req_i <= 1'($urandom());
      lift_lockout_i <= 1'($urandom());
      repeat (3) @(posedge clk_i);
      chk("horn pin", 32'(pin), 32'(!horn_req_i));
      chk("lockout off", 32'(lockout_active_o), 0);
    end
    for (int p = 0; p < 2; p++)
    begin
      wr(A_LOCK, 32'(3 + 4 * p));
      repeat (6)
      begin
        horn_req_i <= 1'($urandom());
        lift_lockout_i <= 1'($urandom());
        repeat (3) @(posedge clk_i);
        chk("ext active", 32'(lockout_active_o), 32'(lift_lockout_i));
        chk("lock pin", 32'(pin), 32'(!(lift_lockout_i ^ p[0])));
      end
    end
    wr(A_LOCK, f3(1, 0, 0));
    lift_lockout_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("int active", 32'(lockout_active_o), 0);
    wr(A_STALL, f3(10, 40, 16));
    speed_est_i <= 8'h03;
    duty_i <= 7'h28;
    repeat (200) @(posedge clk_i);
    chk("duty at limit", 32'(stall_fault_o), 0);
    hold(100);
    @(posedge clk_i);
    speed_est_i <= 8'h0a;
    hold(122);
    chk("timer restart", 32'(stall_fault_o), 0);
    for (int i = 0; i < 20 && stall_fault_o !== 1'b1; i++)
      hold(1);
    chk("stall fault", 32'(stall_fault_o), 1);
    @(posedge clk_i);
    speed_est_i <= 8'h32;
    wr(A_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("stall clear", 32'(stall_fault_o), 0);
    duty_i <= 7'h00;
    do_reset(9'h0e1);
    chk("est reset full", 32'(est), 32'h64);
    do_reset(9'h0d7);
    chk("est below reset", 32'(est), 32'h32);
    wr(A_FACT, f3(1, 10, 0));
    duty_i <= 7'h14;
    repeat (80) @(posedge clk_i);
    e1 = est;
    chk("fast drain", 32'(50 - e1 >= 9 && 50 - e1 <= 11), 1);
    wr(A_FACT, f3(2, 10, 0));
    repeat (78) @(posedge clk_i);
    chk("slow drain", 32'(e1 - est >= 4 && e1 - est <= 6), 1);
    duty_i <= 7'h00;
    wr(A_LOCK, f3(1, 50, 0));
    repeat (3) @(posedge clk_i);
    chk("low charge lock", 32'(lockout_active_o), 1);
    chk("low charge pin", 32'(pin), 0);
    volt_set <= 9'h0f0;
    repeat (4) @(posedge clk_i);
    chk("charging", 32'(charging_o), 1);
    volt_set <= 9'h104;
    repeat (4) @(posedge clk_i);
    chk("charge done", 32'(est), 32'h64);
    volt_set <= 9'h0d7;
    repeat (4) @(posedge clk_i);
    chk("charger off", 32'(charging_o), 0);
    complete_run();
  end
endmodule
`default_nettype wire
